// [design/ieu_core.sv]
// Interrupt entry, return, unlock window, stack pointer and status flags.
// Assumes the core pulses instr_done_i at every instruction boundary and
// stalls while busy_o is high; sources and stack memory share core_clk_i.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Take only with source and global enable
// - Lower source index wins; reset stays outside
// - Entry clears global enable; software may nest
// - Return sets global enable
// - Flag cleared on vectoring or write-one
// - Disabled flags stay latched until served
// - Level sources request only while present
// - One instruction runs after return first
// - Disable instruction blocks same-cycle takes
// - One instruction runs after enable first
// - Status flags never saved nor restored
// - Entry four cycles pushing PC
// - Take only at instruction boundaries or while asleep
// - Sleep wake adds four entry cycles
// - Return four cycles, pop, SP plus two
// - Unlock code opens four-instruction write window
// - No interrupts during unlock window
// - Unlock register reads window state bit 0
// - Sign bit is negative xor overflow
// - Transfer bit stored and loaded
// - Zero, negative, carry, half carry from ALU
// - Push lowers stack pointer by two
module ieu_core #(
    parameter int unsigned          NUM_SRC    = 8,
    parameter logic [NUM_SRC-1:0]   LEVEL_SRC  = '0,
    parameter logic [15:0]          TOP_OF_RAM = 16'h005f
) (
    // Clock and reset.
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    // I/O space access from the core.
    input  wire logic [5:0]          io_addr_i,
    input  wire logic                io_we_i,
    input  wire logic [7:0]          io_wdata_i,
    output logic [7:0]               io_rdata_o,
    // Instruction pipeline events.
    input  wire logic                instr_done_i,
    input  wire logic                sei_i,
    input  wire logic                dis_i,
    input  wire logic                hret_i,
    input  wire logic                sleep_i,
    input  wire logic [15:0]         pc_i,
    // ALU flag update and bit transfer.
    input  wire logic                alu_we_i,
    input  wire logic [7:0]          alu_flags_i,
    input  wire logic                tst_i,
    input  wire logic                tst_bit_i,
    output logic                     t_bit_o,
    // Interrupt sources.
    input  wire logic [NUM_SRC-1:0]  src_event_i,
    input  wire logic [NUM_SRC-1:0]  src_level_i,
    input  wire logic [NUM_SRC-1:0]  src_en_i,
    input  wire logic [NUM_SRC-1:0]  flag_clr_i,
    output logic [NUM_SRC-1:0]       flag_o,
    // Sequencer to the core.
    output logic                     busy_o,
    output logic                     vector_go_o,
    output logic [7:0]               vector_o,
    output logic                     pc_load_o,
    output logic [15:0]              pc_o,
    output logic                     prot_wr_en_o,
    // Stack memory.
    output logic                     stk_we_o,
    output logic                     stk_re_o,
    output logic [15:0]              stk_addr_o,
    output logic [7:0]               stk_wdata_o,
    input  wire logic [7:0]          stk_rdata_i
);
    import ieu_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************

    // Lowest set index wins, as the lowest vector is served first.
    function automatic logic [7:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [7:0] idx;
        idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 8'(i);
            end
        end
        return idx;
    endfunction : first_set

    // ************************************************************
    // State
    // ************************************************************
    ieu_state_t           st_r;        // Sequencer state.
    ieu_state_t           st_nxt;
    logic [2:0]           cnt_r;       // Cycle within a sequence.
    logic [7:0]           stat_r;      // Status flags, bit 4 unused here.
    logic [15:0]          sp_r;        // Stack pointer.
    logic [NUM_SRC-1:0]   flag_r;      // Latched event flags.
    logic                 gap_r;       // One instruction must run first.
    logic [2:0]           win_r;       // Instructions left in unlock window.
    logic [7:0]           vec_r;       // Source being served.
    logic [7:0]           pop_hi_r;    // Popped PC high byte.

    // ************************************************************
    // Decode
    // ************************************************************
    wire logic wr_stat = io_we_i && (io_addr_i == IEU_STAT_ADDR);
    wire logic wr_stl  = io_we_i && (io_addr_i == IEU_STL_ADDR);
    wire logic wr_sth  = io_we_i && (io_addr_i == IEU_STH_ADDR);
    wire logic wr_ulk  = io_we_i && (io_addr_i == IEU_ULK_ADDR);
    // Only the exact code opens the window; anything else is dropped.
    wire logic unlock  = wr_ulk && (io_wdata_i == IEU_UNLOCK_CODE);
    wire logic win_on  = (win_r != 3'h0);

    // Flag sources hold until served; level sources only while present.
    wire logic [NUM_SRC-1:0] pend =
        (flag_r & ~LEVEL_SRC) | (src_level_i & LEVEL_SRC);
    wire logic [NUM_SRC-1:0] elig = pend & src_en_i;
    wire logic [7:0]         sel  = first_set(elig);

    // A disable in this very cycle beats any request.
    wire logic gie_eff = stat_r[IEU_BIT_I] && !dis_i;
    // Awake, takes wait for an instruction boundary; asleep, none runs.
    wire logic boundary = instr_done_i || sleep_i;
    wire logic take = (st_r == IEU_ST_RUN) && boundary && gie_eff
                   && !gap_r && !win_on && !hret_i
                   && (elig != '0);
    wire logic last = (cnt_r == IEU_ENTRY_CYC - 3'h1);

    // ************************************************************
    // Sequencer next state
    // ************************************************************
    // Entry and return run four cycles each; a wake adds four up front.
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            IEU_ST_RUN: begin
                if (take) begin
                    st_nxt = sleep_i ? IEU_ST_WAKE : IEU_ST_ENTRY;
                end else if (hret_i) begin
                    st_nxt = IEU_ST_RETURN;
                end
            end
            IEU_ST_WAKE: begin
                if (cnt_r == IEU_WAKE_CYC - 3'h1) begin
                    st_nxt = IEU_ST_ENTRY;
                end
            end
            IEU_ST_ENTRY: begin
                if (last) begin
                    st_nxt = IEU_ST_RUN;
                end
            end
            IEU_ST_RETURN: begin
                if (cnt_r == IEU_RETURN_CYC - 3'h1) begin
                    st_nxt = IEU_ST_RUN;
                end
            end
            default: begin
                st_nxt = IEU_ST_RUN;
            end
        endcase
    end

    // ************************************************************
    // Sequencer registers
    // ************************************************************
    // The counter restarts on every state change.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_r  <= IEU_ST_RUN;
            cnt_r <= 3'h0;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= (st_nxt != st_r) ? 3'h0 : cnt_r + 3'h1;
        end
    end

    // Vector number is captured on the take and held for the core.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            vec_r <= 8'h00;
        end else if (take) begin
            vec_r <= sel;
        end
    end

    // ************************************************************
    // Interrupt flags
    // ************************************************************
    // A new event beats both the hardware and the write-one clear.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            flag_r <= '0;
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (src_event_i[i]) begin
                    flag_r[i] <= 1'b1;
                end else if (flag_clr_i[i]) begin
                    flag_r[i] <= 1'b0;
                end else if (take && (sel == 8'(i))) begin
                    flag_r[i] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // Instruction gaps and unlock window
    // ************************************************************
    // After a return or an enable, one instruction must retire first.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            gap_r <= 1'b0;
        end else if (sei_i || (st_r == IEU_ST_RETURN)) begin
            gap_r <= 1'b1;
        end else if (instr_done_i) begin
            gap_r <= 1'b0;
        end
    end

    // The window counts instructions, not clocks, so stalls stretch it.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            win_r <= 3'h0;
        end else if (unlock) begin
            win_r <= IEU_UNLOCK_INSTRS;
        end else if (win_on && instr_done_i) begin
            win_r <= win_r - 3'h1;
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    // Entry never saves these and return never restores them; only the
    // global enable bit is touched by the sequencer.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stat_r <= IEU_STAT_RST;
        end else begin
            if (wr_stat) begin
                stat_r[5:0] <= io_wdata_i[5:0];
            end else if (alu_we_i) begin
                stat_r[IEU_BIT_H] <= alu_flags_i[IEU_BIT_H];
                stat_r[IEU_BIT_V] <= alu_flags_i[IEU_BIT_V];
                stat_r[IEU_BIT_N] <= alu_flags_i[IEU_BIT_N];
                stat_r[IEU_BIT_Z] <= alu_flags_i[IEU_BIT_Z];
                stat_r[IEU_BIT_C] <= alu_flags_i[IEU_BIT_C];
            end
            if (tst_i) begin
                stat_r[IEU_BIT_T] <= tst_bit_i;
            end else if (wr_stat) begin
                stat_r[IEU_BIT_T] <= io_wdata_i[IEU_BIT_T];
            end
            // Hardware clears win over software sets on entry.
            if (take || dis_i) begin
                stat_r[IEU_BIT_I] <= 1'b0;
            end else if ((st_r == IEU_ST_RETURN) && (st_nxt == IEU_ST_RUN)) begin
                stat_r[IEU_BIT_I] <= 1'b1;
            end else if (sei_i) begin
                stat_r[IEU_BIT_I] <= 1'b1;
            end else if (wr_stat) begin
                stat_r[IEU_BIT_I] <= io_wdata_i[IEU_BIT_I];
            end
        end
    end

    // ************************************************************
    // Stack pointer
    // ************************************************************
    // The stack grows down; the PC takes two bytes either way.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sp_r <= TOP_OF_RAM;
        end else if ((st_r == IEU_ST_ENTRY) && last) begin
            sp_r <= sp_r - IEU_SP_STEP;
        end else if ((st_r == IEU_ST_RETURN) && (st_nxt == IEU_ST_RUN)) begin
            sp_r <= sp_r + IEU_SP_STEP;
        end else if (wr_stl) begin
            sp_r[7:0] <= io_wdata_i;
        end else if (wr_sth) begin
            sp_r[15:8] <= io_wdata_i;
        end
    end

    // ************************************************************
    // Stack memory port
    // ************************************************************
    // Entry writes low byte at SP, high byte at SP-1. Return reads them
    // back in reverse; read data arrives one cycle after the strobe.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stk_we_o    <= 1'b0;
            stk_re_o    <= 1'b0;
            stk_addr_o  <= 16'h0000;
            stk_wdata_o <= 8'h00;
        end else begin
            stk_we_o <= (st_r == IEU_ST_ENTRY) && (cnt_r < 3'h2);
            stk_re_o <= (st_r == IEU_ST_RETURN) && (cnt_r < 3'h2);
            if (st_r == IEU_ST_ENTRY) begin
                stk_addr_o  <= sp_r - 16'(cnt_r);
                stk_wdata_o <= (cnt_r == 3'h0) ? pc_i[7:0] : pc_i[15:8];
            end else begin
                stk_addr_o  <= sp_r + 16'(cnt_r) + IEU_SP_ONE;
                stk_wdata_o <= 8'h00;
            end
        end
    end

    // Popped high byte is held until the low byte lands.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pop_hi_r <= 8'h00;
        end else if ((st_r == IEU_ST_RETURN) && (cnt_r == 3'h2)) begin
            pop_hi_r <= stk_rdata_i;
        end
    end

    // ************************************************************
    // Core handshake outputs
    // ************************************************************
    // Vector go and PC load pulse for one cycle as each sequence ends.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            busy_o      <= 1'b0;
            vector_go_o <= 1'b0;
            vector_o    <= 8'h00;
            pc_load_o   <= 1'b0;
            pc_o        <= 16'h0000;
        end else begin
            busy_o      <= (st_nxt != IEU_ST_RUN);
            vector_go_o <= (st_r == IEU_ST_ENTRY) && last;
            vector_o    <= vec_r;
            pc_load_o   <= (st_r == IEU_ST_RETURN) && (cnt_r == 3'h3);
            if ((st_r == IEU_ST_RETURN) && (cnt_r == 3'h3)) begin
                pc_o <= {pop_hi_r, stk_rdata_i};
            end
        end
    end

    // ************************************************************
    // Read back and status outputs
    // ************************************************************
    // Sign is formed on read so it can never drift from N and V.
    wire logic       sign_bit = stat_r[IEU_BIT_N] ^ stat_r[IEU_BIT_V];
    wire logic [7:0] stat_view = {stat_r[7:5], sign_bit, stat_r[3:0]};
    wire logic [7:0] ulk_view  = {7'h00, win_on};
    wire logic [7:0] rd_mux =
        (io_addr_i == IEU_STAT_ADDR) ? stat_view :
        (io_addr_i == IEU_STL_ADDR)  ? sp_r[7:0] :
        (io_addr_i == IEU_STH_ADDR)  ? sp_r[15:8] :
        (io_addr_i == IEU_ULK_ADDR)  ? ulk_view : 8'h00;

    // Read data is registered and shows one cycle after the address.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            io_rdata_o   <= 8'h00;
            t_bit_o      <= 1'b0;
            flag_o       <= '0;
            prot_wr_en_o <= 1'b0;
        end else begin
            io_rdata_o   <= rd_mux;
            t_bit_o      <= tst_i ? tst_bit_i : stat_r[IEU_BIT_T];
            flag_o       <= flag_r;
            prot_wr_en_o <= unlock || (win_r > 3'h1)
                         || (win_on && !instr_done_i);
        end
    end

endmodule : ieu_core

`default_nettype wire

// [design/ieu_pkg.sv]
// Constants shared by the interrupt entry and status unit.
// Assumes an 8-bit core with a 64-entry I/O space and a byte-wide stack.
package ieu_pkg;

    // ************************************************************
    // I/O register offsets
    // ************************************************************
    localparam logic [5:0] IEU_ULK_ADDR  = 6'h3c; // Unlock register.
    localparam logic [5:0] IEU_STL_ADDR  = 6'h3d; // Stack pointer low.
    localparam logic [5:0] IEU_STH_ADDR  = 6'h3e; // Stack pointer high.
    localparam logic [5:0] IEU_STAT_ADDR = 6'h3f; // Status flags.

    // ************************************************************
    // Status flag bit positions and reset value
    // ************************************************************
    localparam int unsigned IEU_BIT_I = 7; // Global enable.
    localparam int unsigned IEU_BIT_T = 6; // Transfer bit.
    localparam int unsigned IEU_BIT_H = 5; // Half carry.
    localparam int unsigned IEU_BIT_S = 4; // Sign.
    localparam int unsigned IEU_BIT_V = 3; // Overflow.
    localparam int unsigned IEU_BIT_N = 2; // Negative.
    localparam int unsigned IEU_BIT_Z = 1; // Zero.
    localparam int unsigned IEU_BIT_C = 0; // Carry.
    localparam logic [7:0]  IEU_STAT_RST = 8'h00;

    // ************************************************************
    // Unlock window
    // ************************************************************
    localparam logic [7:0] IEU_UNLOCK_CODE   = 8'hd8; // Opens the window.
    localparam logic [2:0] IEU_UNLOCK_INSTRS = 3'h4;  // Instructions open.
    localparam int unsigned IEU_ULK_ACT_BIT  = 0;     // Reads one when open.

    // ************************************************************
    // Sequence lengths in core clock cycles, and stack pointer steps
    // ************************************************************
    localparam logic [2:0]  IEU_ENTRY_CYC  = 3'h4; // Entry, pushes the PC.
    localparam logic [2:0]  IEU_WAKE_CYC   = 3'h4; // Extra cycles from sleep.
    localparam logic [2:0]  IEU_RETURN_CYC = 3'h4; // Return, pops the PC.
    localparam logic [15:0] IEU_SP_STEP    = 16'h0002; // PC is two bytes.
    localparam logic [15:0] IEU_SP_ONE     = 16'h0001;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        IEU_ST_RUN    = 4'b0001,
        IEU_ST_WAKE   = 4'b0010,
        IEU_ST_ENTRY  = 4'b0100,
        IEU_ST_RETURN = 4'b1000
    } ieu_state_t;

endpackage : ieu_pkg

// [sim/ieu_core_properties.sv]
// Concurrent checks on the ports of the interrupt entry and status unit.
// Assumes a single core clock and the sequencer timing of the hand-over.
`timescale 1ns/10ps
`default_nettype none
module ieu_core_properties
    import ieu_pkg::*;
(
    // Clock and reset.
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    // Watched ports.
    input wire logic [5:0]  io_addr_i,
    input wire logic [7:0]  io_rdata_o,
    input wire logic        dis_i,
    input wire logic        hret_i,
    input wire logic        sleep_i,
    input wire logic        busy_o,
    input wire logic        vector_go_o,
    input wire logic        pc_load_o,
    input wire logic        prot_wr_en_o,
    input wire logic        stk_we_o,
    input wire logic        stk_re_o,
    input wire logic [15:0] stk_addr_o
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Awake entry pushes two bytes downward, then jumps.
    chk_entry_push: assert property (
        $rose(busy_o) && !$past(hret_i) && !$past(sleep_i) |-> ##1 stk_we_o
        ##1 (stk_we_o && stk_addr_o == $past(stk_addr_o) - 16'h1) ##1 !stk_we_o ##1 vector_go_o)
        else $error("entry push sequence wrong");
    // Return pops two bytes upward, then reloads the PC.
    chk_return_pop: assert property (
        $rose(busy_o) && $past(hret_i) |-> ##1 stk_re_o
        ##1 (stk_re_o && stk_addr_o == $past(stk_addr_o) + 16'h1) ##2 pc_load_o)
        else $error("return pop sequence wrong");
    // A sleeping take may add four cycles, never more.
    chk_busy_bound: assert property (
        $rose(busy_o) |-> ##[4:8] (vector_go_o || pc_load_o))
        else $error("sequence too long");
    // Upper unlock bits always read zero.
    chk_unlock_read: assert property (
        $past(io_addr_i) == IEU_ULK_ADDR |-> io_rdata_o[7:1] == 7'h00)
        else $error("unlock upper bits not zero");
    // The sign bit tracks negative xor overflow.
    chk_sign_xor: assert property (
        $past(io_addr_i) == IEU_STAT_ADDR |-> io_rdata_o[4] == (io_rdata_o[2] ^ io_rdata_o[3]))
        else $error("sign bit wrong");
    // No take while the unlock window is open.
    chk_window_quiet: assert property (
        prot_wr_en_o && !busy_o && !hret_i |=> !busy_o)
        else $error("take inside unlock window");
    // The disable instruction blocks a take in its own cycle.
    chk_dis_block: assert property (
        dis_i && !hret_i && !busy_o |=> !busy_o)
        else $error("take beside disable");
    // One main instruction runs after a return.
    chk_return_gap: assert property (
        pc_load_o && !hret_i |=> !busy_o)
        else $error("take right after return");

    cover property (vector_go_o && sleep_i);
    cover property (pc_load_o);
    cover property (prot_wr_en_o);
endmodule : ieu_core_properties

bind ieu_core ieu_core_properties u_props (.core_clk_i, .rst_i, .io_addr_i, .io_rdata_o,
    .dis_i, .hret_i, .sleep_i, .busy_o, .vector_go_o, .pc_load_o, .prot_wr_en_o,
    .stk_we_o, .stk_re_o, .stk_addr_o);
`default_nettype wire

// [sim/ieu_core_tb.sv]
// Self-checking bench for the interrupt entry and status unit.
// Assumes the stack model answers one cycle after each read strobe.
`timescale 1ns/10ps
`default_nettype none
module ieu_core_tb;
    import ieu_pkg::*;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        core_clk_i, rst_i, io_we_i, instr_done_i, sei_i, dis_i, hret_i, sleep_i;
    logic        alu_we_i, tst_i, tst_bit_i, t_bit_o, busy_o, vector_go_o, pc_load_o;
    logic        prot_wr_en_o, stk_we_o, stk_re_o;
    logic [3:0]  src_event_i, src_level_i, src_en_i, flag_clr_i, flag_o;
    logic [5:0]  io_addr_i;
    logic [7:0]  io_wdata_i, io_rdata_o, alu_flags_i, vector_o, stk_wdata_o, stk_rdata_i;
    logic [15:0] pc_i, pc_o, stk_addr_o;
    int          fails = 0, cmp_count = 0, na, nr, ns;
    // Pulse masks: retire, enable, disable, return, flag load, bit store.
    localparam logic [5:0] DN = 6'h20, SE = 6'h10, CL = 6'h08, RT = 6'h04, AL = 6'h02, BS = 6'h01;
    // Flag loads beside the status value each should read back as.
    logic [7:0]  row_in[5]  = '{8'h04, 8'h08, 8'h0c, 8'hff, 8'h21};
    logic [7:0]  row_exp[5] = '{8'h14, 8'h18, 8'h0c, 8'h2f, 8'h21};
    logic [5:0]  rst_adr[5] = '{6'h3c, 6'h3d, 6'h3e, 6'h3f, 6'h10};
    logic [7:0]  rst_val[5] = '{8'h00, 8'h5f, 8'h00, 8'h00, 8'h00};

    ieu_core #(.NUM_SRC(4), .LEVEL_SRC(4'h8)) dut (.*);
    ieu_stack_model stk (.clk_i(core_clk_i), .we_i(stk_we_o), .re_i(stk_re_o),
        .addr_i(stk_addr_o), .wdata_i(stk_wdata_o), .rdata_o(stk_rdata_i));

    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : cyc

    // One-cycle strobe of instruction events, with flag or bit data.
    task automatic pulse(input logic [5:0] m, input logic [7:0] f = 8'h00);
        @(posedge core_clk_i);
        {instr_done_i, sei_i, dis_i, hret_i, alu_we_i, tst_i} <= m;
        alu_flags_i <= f;
        tst_bit_i <= f[0];
        @(posedge core_clk_i);
        {instr_done_i, sei_i, dis_i, hret_i, alu_we_i, tst_i} <= 6'h00;
    endtask : pulse

    task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_we_i <= 1'b1;
        @(posedge core_clk_i);
        io_we_i <= 1'b0;
    endtask : io_wr

    // Read data is registered, so it is looked at one edge after the address.
    task automatic io_chk(input logic [5:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        io_addr_i <= a;
        cyc(1);
        check(16'(io_rdata_o), 16'(e));
    endtask : io_chk

    // Counts edges until a jump or PC reload; a hang ends the run.
    task automatic wait_go(output int n);
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (vector_go_o !== 1'b1 && pc_load_o !== 1'b1 && n < 20);
        if (n == 20) begin
            fails++;
            print_verdict();
        end
    endtask : wait_go

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        {rst_i, io_we_i, instr_done_i, sei_i, dis_i, hret_i, sleep_i, alu_we_i} = 8'h80;
        {tst_i, tst_bit_i, src_event_i, src_level_i, src_en_i, flag_clr_i} = '0;
        {io_addr_i, io_wdata_i, alu_flags_i} = '0;
        pc_i = 16'h1234;
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) io_chk(rst_adr[i], rst_val[i]);
        for (int i = 0; i < 5; i++) begin
            pulse(AL, row_in[i]);
            io_chk(IEU_STAT_ADDR, row_exp[i]);
        end
        pulse(BS, 8'h01);
        cyc(0);
        check(16'(t_bit_o), 16'h1);
        io_chk(IEU_STAT_ADDR, 8'h61);
        pulse(BS);
        // Latch three flags with only the first source enabled.
        @(posedge core_clk_i);
        src_event_i <= 4'h7;
        src_en_i <= 4'h1;
        @(posedge core_clk_i);
        src_event_i <= 4'h0;
        pulse(SE);
        pulse(DN);
        cyc(2);
        check(16'(busy_o), 16'h0);
        check(16'(flag_o), 16'h7);
        pulse(CL | DN);
        cyc(2);
        check(16'(busy_o), 16'h0);
        io_chk(IEU_STAT_ADDR, 8'h21);
        io_wr(IEU_ULK_ADDR, 8'h55);
        io_chk(IEU_ULK_ADDR, 8'h00);
        io_wr(IEU_ULK_ADDR, IEU_UNLOCK_CODE);
        io_chk(IEU_ULK_ADDR, 8'h01);
        pulse(SE);
        repeat (3) pulse(DN);
        cyc(2);
        check(16'(busy_o), 16'h0);
        check(16'(prot_wr_en_o), 16'h1);
        pulse(DN);
        cyc(0);
        check(16'(prot_wr_en_o), 16'h0);
        cyc(3);
        check(16'(busy_o), 16'h0);
        pulse(DN);
        wait_go(na);
        check(16'(vector_o), 16'h0);
        io_chk(IEU_STAT_ADDR, 8'h21);
        io_chk(IEU_STL_ADDR, 8'h5d);
        check({stk.mem[8'h5e], stk.mem[8'h5f]}, pc_i);
        check(16'(flag_o), 16'h6);
        pulse(RT);
        wait_go(nr);
        check(pc_o, pc_i);
        check(16'(nr), 16'(na));
        io_chk(IEU_STAT_ADDR, 8'ha1);
        io_chk(IEU_STL_ADDR, 8'h5f);
        @(posedge core_clk_i);
        src_en_i <= 4'h6;
        pulse(DN);
        cyc(2);
        check(16'(busy_o), 16'h0);
        pulse(DN);
        wait_go(na);
        check(16'(vector_o), 16'h1);
        pulse(RT);
        wait_go(nr);
        @(posedge core_clk_i);
        flag_clr_i <= 4'h4;
        @(posedge core_clk_i);
        flag_clr_i <= 4'h0;
        repeat (2) pulse(DN);
        cyc(2);
        check(16'(flag_o), 16'h0);
        check(16'(busy_o), 16'h0);
        // A level request that vanishes before enabling is lost.
        @(posedge core_clk_i);
        src_en_i <= 4'h0;
        src_level_i <= 4'h8;
        @(posedge core_clk_i);
        src_level_i <= 4'h0;
        src_en_i <= 4'h8;
        pulse(DN);
        cyc(2);
        check(16'(busy_o), 16'h0);
        @(posedge core_clk_i);
        src_level_i <= 4'h8;
        sleep_i <= 1'b1;
        @(posedge core_clk_i);
        wait_go(ns);
        check(16'(ns), 16'(na + 4));
        check(16'(vector_o), 16'h3);
        @(posedge core_clk_i);
        sleep_i <= 1'b0;
        print_verdict();
    end
endmodule : ieu_core_tb
`default_nettype wire

// [sim/ieu_stack_model.sv]
// Byte-wide stack memory on the far side of the unit.
// Assumes the same clock; only the low address byte is decoded.
`timescale 1ns/10ps
`default_nettype none
module ieu_stack_model (
    input  wire logic        clk_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    output var logic [7:0]   rdata_o = 8'h00
);
    logic [7:0] mem [0:255]; // Storage.

    // Data is valid only the cycle after a read; otherwise it toggles,
    // so a late sample by the unit cannot pass by luck.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i[7:0]] <= wdata_i;
        end
        rdata_o <= re_i ? mem[addr_i[7:0]] : ~rdata_o;
    end
endmodule : ieu_stack_model
`default_nettype wire
